// ### dv/pops_pulse_src.sv
// Sensor pulse source model driving the counter input
`timescale 1ns/1ps
`default_nettype none
module pops_pulse_src (
	input wire logic clock_in,
	input wire logic [7:0] num_in,
	input wire logic go_in,
	output logic pulse_out,
	output logic busy_out
);
	logic [7:0] left_r = 8'h00;
	logic [1:0] ph_r = 2'h0;
	always_ff @(posedge clock_in) begin
		if (go_in) begin
			left_r <= num_in;
			ph_r <= 2'h0;
		end else if (left_r != 8'h00) begin
			ph_r <= ph_r + 2'h1;
			if (ph_r == 2'h3) begin
				left_r <= left_r - 8'h01;
			end
		end
	end
	// Two high, two low; the line idles low like a pulled-down sensor
	assign pulse_out = (left_r != 8'h00) && !ph_r[1];
	assign busy_out = (left_r != 8'h00);
endmodule : pops_pulse_src
`default_nettype wire

// ### dv/pops_top_tb.sv
// Self-checking bench of the pulse output and precise stop block
`timescale 1ns/1ps
`default_nettype none
module pops_top_tb import pops_pkg::*;;
	logic clk = 1'b0;
	logic srst, cyc, stb, we, start, go, pls, busy, ack, dout, run, stop;
	logic [7:0] adr, npl;
	logic [3:0] sel;
	logic [31:0] wdat, stat, rdat;
	logic [15:0] ctrl, speed;
	pops_drive_s drv;
	logic [31:0] exp_q[$];
	logic [4:0] pc[6] = '{SEL_PULSE_REF, SEL_PULSE_FB, SEL_PULSE_FREQ, SEL_PULSE_AMPS,
		SEL_PULSE_POWER, SEL_PULSE_TEMP};
	int failures = 0;
	int cmp_count = 0;
	int cyc_n = 0;
	int n;
	always #2.5 clk = ~clk;
	pops_top #(.MS_CYCLES(10)) dut_u (.clock_in(clk), .srst_in(srst), .wb_cyc_in(cyc),
		.wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
		.wb_ack_out(ack), .wb_dat_out(rdat), .status_cond_in(stat), .ctrl_word_in(ctrl),
		.drive_in(drv), .speed_in(speed), .start_in(start), .count_pulse_in(pls),
		.dout_out(dout), .run_out(run), .stop_out(stop));
	pops_pulse_src src_u (.clock_in(clk), .num_in(npl), .go_in(go), .pulse_out(pls),
		.busy_out(busy));
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			failures++;
			$display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check
	task automatic final_report();
		$display("%0d comparisons, %0d mismatches", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : final_report
	// Request held until ack is sampled; no fixed latency assumed
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		@(posedge clk);
		while (ack !== 1'b1) begin
			@(posedge clk);
		end
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask : rd
	task automatic tdone(input string s);
		$display("test %s finished", s);
	endtask : tdone
	task automatic send(input logic [7:0] k);
		npl <= k;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		@(posedge clk);
		while (busy === 1'b1) begin
			@(posedge clk);
		end
		repeat (3) @(posedge clk);
	endtask : send
	// Start stays a plain level so the pulse-start function is never used
	task automatic cnt_stop(input logic [7:0] k, input logic [31:0] ramp);
		start <= 1'b1;
		speed <= 16'd100;
		repeat (3) @(posedge clk);
		check(32'(run), 32'h1);
		send(k - 8'h01);
		check(32'(stop), 32'h0);
		send(8'h01);
		check(32'({run, stop}), 32'h1);
		start <= 1'b0;
		send(8'h03);
		speed <= 16'h0;
		repeat (3) @(posedge clk);
		rd(ADR_RAMPCNT, ramp);
		rd(ADR_COUNT, 32'd5);
		rd(ADR_STATUS, 32'h14);
	endtask : cnt_stop
	task automatic cmp_stop(input int m, input logic [15:0] spd, input int lo, input int hi);
		wr(ADR_CTRL, 32'(m) << 8);
		start <= 1'b1;
		speed <= spd;
		repeat (3) @(posedge clk);
		start <= 1'b0;
		n = 0;
		while (run === 1'b1 && n < 300) begin
			@(posedge clk);
			n++;
		end
		check(32'(n >= lo && n <= hi), 32'h1);
		speed <= 16'h0;
		repeat (3) @(posedge clk);
	endtask : cmp_stop
	// Read data is compared against the oldest note when ack shows up
	always @(posedge clk) begin
		cyc_n++;
		if (ack === 1'b1 && we === 1'b0) begin
			check(rdat, exp_q.pop_front());
		end
		if (cyc_n == 90000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		srst = 1'b1;
		{cyc, stb, we, start, go} = 5'h00;
		adr = 8'h00;
		npl = 8'h00;
		sel = 4'hf;
		wdat = 32'h0;
		stat = 32'h0;
		ctrl = 16'h0;
		speed = 16'h0;
		drv = {16'd1107, 16'd100, 16'd1100, 16'd600, 16'd50, 16'd550, 16'd600, 16'd500,
			16'd900, 16'd800, 16'd400, 16'd300, 16'd120};
		void'($urandom(23772));
		repeat (3) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		rd(ADR_CTRL, 32'h0);
		rd(ADR_PMAX, 32'd5000);
		rd(ADR_TARGET, 32'd100000);
		rd(ADR_DELAY, 32'd10);
		rd(8'h1c, 32'h0);
		wr(ADR_PMAX, 32'd100);
		rd(ADR_PMAX, 32'd150);
		wr(ADR_TARGET, 32'hfffff);
		rd(ADR_TARGET, 32'd999999);
		wr(ADR_DELAY, 32'h7f);
		rd(ADR_DELAY, 32'd100);
		wr(ADR_DELAY, 32'd10);
		tdone("registers");
		for (int c = 1; c < 32; c++) begin
			if (c != 21 && (c < 26 || c == 31)) begin
				wr(ADR_CTRL, 32'(c));
				repeat (3) begin
					stat <= $urandom;
					ctrl <= 16'($urandom);
					repeat (2) @(posedge clk);
					check(32'(dout), 32'(c == 31 ? ctrl[CTRL_BIT_POS] : stat[c]));
				end
			end
		end
		tdone("status");
		// Every quantity sits above its high limit, so each code must clamp to full scale
		wr(ADR_PMAX, 32'd10000);
		foreach (pc[i]) begin
			wr(ADR_CTRL, 32'h0);
			wr(ADR_CTRL, 32'(pc[i]));
			n = 0;
			while (dout === 1'b0 && n < 12000) begin
				@(posedge clk);
				n++;
			end
			check(32'(n > 9980 && n < 10020), 32'h1);
		end
		// An empty reference range must freeze the output where it stands
		drv.ref_max <= drv.ref_min;
		wr(ADR_CTRL, 32'(SEL_PULSE_REF));
		repeat (20) @(posedge clk);
		check(32'(dout), 32'h1);
		tdone("pulse");
		wr(ADR_TARGET, 32'd5);
		wr(ADR_CTRL, 32'h100);
		cnt_stop(8'h05, 32'h0);
		wr(ADR_CTRL, 32'h200);
		cnt_stop(8'h05, 32'h3);
		cnt_stop(8'h02, 32'h3);
		tdone("counter");
		cmp_stop(3, 16'd250, 45, 58);
		cmp_stop(3, 16'd500, 0, 5);
		cmp_stop(0, 16'd250, 0, 5);
		cmp_stop(4, 16'd100, 75, 88);
		cmp_stop(5, 16'd400, 15, 28);
		wr(ADR_CTRL, 32'h607);
		rd(ADR_CTRL, 32'h507);
		tdone("compensated");
		final_report();
	end
endmodule : pops_top_tb
`default_nettype wire

// ### logic/pops_pkg.sv
// Constants, types and a helper function of the pulse output and precise stop block
package pops_pkg;
	localparam int CLK_HZ = 200_000_000;
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_PER_S = 1000;
	localparam logic [26:0] HALF_HZ = 27'(CLK_HZ / 2);
	localparam logic [7:0] ADR_CTRL = 8'h00;
	localparam logic [7:0] ADR_PMAX = 8'h04;
	localparam logic [7:0] ADR_TARGET = 8'h08;
	localparam logic [7:0] ADR_DELAY = 8'h0c;
	localparam logic [7:0] ADR_STATUS = 8'h10;
	localparam logic [7:0] ADR_COUNT = 8'h14;
	localparam logic [7:0] ADR_RAMPCNT = 8'h18;
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_MODE_LSB = 8;
	localparam logic [4:0] SEL_RST = 5'h00;
	localparam logic [2:0] MODE_RST = 3'h0;
	localparam logic [13:0] PMAX_MIN_HZ = 14'd150;
	localparam logic [13:0] PMAX_MAX_HZ = 14'd10000;
	localparam logic [13:0] PMAX_RST_HZ = 14'd5000;
	localparam logic [19:0] TARGET_MAX = 20'd999999;
	localparam logic [19:0] TARGET_RST = 20'd100000;
	localparam logic [6:0] DELAY_MAX_MS = 7'd100;
	localparam logic [6:0] DELAY_RST_MS = 7'd10;
	localparam int COUNT_IN_MAX_HZ = 67600;
	localparam int COUNT_GAP_CYC = CLK_HZ / COUNT_IN_MAX_HZ;
	localparam logic [4:0] SEL_STAT_LAST = 5'd20;
	localparam logic [4:0] SEL_PULSE_REF = 5'd21;
	localparam logic [4:0] SEL_STAT2_FIRST = 5'd22;
	localparam logic [4:0] SEL_STAT2_LAST = 5'd25;
	localparam logic [4:0] SEL_PULSE_FB = 5'd26;
	localparam logic [4:0] SEL_PULSE_FREQ = 5'd27;
	localparam logic [4:0] SEL_PULSE_AMPS = 5'd28;
	localparam logic [4:0] SEL_PULSE_POWER = 5'd29;
	localparam logic [4:0] SEL_PULSE_TEMP = 5'd30;
	localparam logic [4:0] SEL_CTRL_BIT = 5'd31;
	localparam int CTRL_BIT_POS = 12;
	localparam logic [15:0] TEMP_LOW_C = 16'd20;
	localparam logic [15:0] TEMP_HIGH_C = 16'd100;
	localparam logic [2:0] MODE_RAMP = 3'd0;
	localparam logic [2:0] MODE_CNT_RST = 3'd1;
	localparam logic [2:0] MODE_CNT_NORST = 3'd2;
	localparam logic [2:0] MODE_SPD = 3'd3;
	localparam logic [2:0] MODE_SPD_CNT_RST = 3'd4;
	localparam logic [2:0] MODE_SPD_CNT_NORST = 3'd5;

	typedef enum logic [3:0] {
		POPS_IDLE = 4'b0001,
		POPS_RUN = 4'b0010,
		POPS_DELAY = 4'b0100,
		POPS_RAMP = 4'b1000
	} pops_state_e;

	typedef struct packed {
		logic [15:0] ref_val;
		logic [15:0] ref_min;
		logic [15:0] ref_max;
		logic [15:0] fb_val;
		logic [15:0] process_value_low;
		logic [15:0] process_value_high;
		logic [15:0] pulse_out_motor_freq;
		logic [15:0] freq_high;
		logic [15:0] amps;
		logic [15:0] inverter_rated_amps;
		logic [15:0] power;
		logic [15:0] power_nom;
		logic [15:0] temp_c;
	} pops_drive_s;

	typedef struct packed {
		logic [15:0] value;
		logic [15:0] low;
		logic [15:0] high;
	} pops_scale_s;

	function automatic logic [31:0] pops_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] sel);
		logic [31:0] m;
		m = old_v;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				m[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return m;
	endfunction : pops_merge
endpackage : pops_pkg

// ### logic/pops_top.sv
// Pulse/status output and precise stop counter with a Wishbone register slave
// How it works
// - Status codes drive the output high exactly while the chosen condition holds.
// - Code 31 makes the output follow control word bit 12.
// - Code 21 pulses at a rate proportional to reference between its limits.
// - Code 26 pulses proportional to feedback between its low and high limits.
// - Code 27 pulses proportional to output frequency from zero to high limit.
// - Code 28 pulses proportional to output current up to rated current.
// - Code 29 pulses proportional to power, full scale at nominal motor power.
// - Code 30 pulses proportional to heatsink temperature, 20 to 100 degrees.
// - Full-scale pulse rate is programmable 150 to 10000 Hz, default 5000.
// - Six stop modes 0 to 5 combine counter, speed compensation and reset.
// - Counter modes run until target pulses are counted, then stop internally.
// - Counting begins at the stop-to-start edge of the start signal.
// - Compensated modes delay an external stop more the slower the motor runs.
// - Counter with reset clears ramp-down pulses after every precise stop.
// - Counter without reset deducts ramp-down pulses from the next target.
// - Count target is programmable 0 to 999999, default 100000.
// - Count input registers every rising edge, fast enough for 67.6 kHz.
// - System delay setting 0 to 100 ms, default 10, acts only when compensated.
`timescale 1ns/1ps
`default_nettype none
module pops_top import pops_pkg::*; #(
	parameter int MS_CYCLES = CLK_HZ / MS_PER_S
) (
	input wire logic clock_in,
	input wire logic srst_in,
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic wb_ack_out,
	output logic [31:0] wb_dat_out,
	input wire logic [31:0] status_cond_in,
	input wire logic [15:0] ctrl_word_in,
	input wire pops_drive_s drive_in,
	input wire logic [15:0] speed_in,
	input wire logic start_in,
	input wire logic count_pulse_in,
	output logic dout_out,
	output logic run_out,
	output logic stop_out
);
	logic ack_r;
	logic [31:0] rdat_r;
	logic [4:0] sel_r;
	logic [2:0] mode_r;
	logic [13:0] pmax_r;
	logic [19:0] target_r;
	logic [6:0] delay_r;
	logic dout_r;
	logic run_r;
	logic stop_r;
	logic [42:0] acc_r;
	logic start_d_r;
	logic cpin_d_r;
	logic [19:0] cnt_r;
	logic [19:0] ramp_cnt_r;
	logic [31:0] ms_cnt_r;
	logic [23:0] dly_acc_r;
	logic [22:0] dly_goal_r;
	pops_state_e state_r;
	pops_state_e state_nxt;

	// Bus decode; ack lasts one cycle so a held request is taken once
	wire req = wb_cyc_in & wb_stb_in & ~ack_r;
	// Writes land at the edge where the master samples ack, never at the taking edge
	wire wr = wb_cyc_in & wb_stb_in & wb_we_in & ack_r;
	wire [31:0] ctrl_rd = {21'h0, mode_r, 3'h0, sel_r};
	wire [31:0] ctrl_m = pops_merge(ctrl_rd, wb_dat_in, wb_sel_in);
	wire [31:0] pmax_m = pops_merge({18'h0, pmax_r}, wb_dat_in, wb_sel_in);
	wire [31:0] target_m = pops_merge({12'h0, target_r}, wb_dat_in, wb_sel_in);
	wire [31:0] delay_m = pops_merge({25'h0, delay_r}, wb_dat_in, wb_sel_in);
	wire [2:0] mode_m = ctrl_m[CTRL_MODE_LSB +: 3];
	// Illegal mode codes 6 and 7 are ignored rather than aliased
	wire mode_ok = mode_m <= MODE_SPD_CNT_NORST;
	// Out-of-range writes saturate so the counters never see an illegal setting
	wire [13:0] pmax_nxt = (pmax_m > {18'h0, PMAX_MAX_HZ}) ? PMAX_MAX_HZ :
		(pmax_m < {18'h0, PMAX_MIN_HZ}) ? PMAX_MIN_HZ : pmax_m[13:0];
	wire [19:0] target_nxt = (target_m > {12'h0, TARGET_MAX}) ? TARGET_MAX :
		target_m[19:0];
	wire [6:0] delay_nxt = (delay_m > {25'h0, DELAY_MAX_MS}) ? DELAY_MAX_MS :
		delay_m[6:0];
	wire [31:0] status_rd = {24'h0, state_r, 1'b0, stop_r, run_r, dout_r};
	wire [31:0] rd_nxt = (wb_adr_in == ADR_CTRL) ? ctrl_rd :
		(wb_adr_in == ADR_PMAX) ? {18'h0, pmax_r} :
		(wb_adr_in == ADR_TARGET) ? {12'h0, target_r} :
		(wb_adr_in == ADR_DELAY) ? {25'h0, delay_r} :
		(wb_adr_in == ADR_STATUS) ? status_rd :
		(wb_adr_in == ADR_COUNT) ? {12'h0, cnt_r} :
		(wb_adr_in == ADR_RAMPCNT) ? {12'h0, ramp_cnt_r} : 32'h0;

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ack_r <= 1'b0;
			rdat_r <= 32'h0;
		end else begin
			ack_r <= req;
			rdat_r <= req ? rd_nxt : rdat_r;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			sel_r <= SEL_RST;
			mode_r <= MODE_RST;
			pmax_r <= PMAX_RST_HZ;
			target_r <= TARGET_RST;
			delay_r <= DELAY_RST_MS;
		end else if (wr) begin
			if (wb_adr_in == ADR_CTRL) begin
				sel_r <= ctrl_m[CTRL_SEL_LSB +: 5];
				mode_r <= mode_ok ? mode_m : mode_r;
			end
			if (wb_adr_in == ADR_PMAX) begin
				pmax_r <= pmax_nxt;
			end
			if (wb_adr_in == ADR_TARGET) begin
				target_r <= target_nxt;
			end
			if (wb_adr_in == ADR_DELAY) begin
				delay_r <= delay_nxt;
			end
		end
	end

	// Pulse output: phase accumulator avoids a divider; each wrap is a half period
	wire pick_ref = sel_r == SEL_PULSE_REF;
	wire pick_fb = sel_r == SEL_PULSE_FB;
	wire pick_freq = sel_r == SEL_PULSE_FREQ;
	wire pick_amps = sel_r == SEL_PULSE_AMPS;
	wire pick_pow = sel_r == SEL_PULSE_POWER;
	wire pick_temp = sel_r == SEL_PULSE_TEMP;
	wire is_pulse = pick_ref | pick_fb | pick_freq | pick_amps | pick_pow | pick_temp;
	wire pops_scale_s scl = pick_ref ? {drive_in.ref_val, drive_in.ref_min, drive_in.ref_max} :
		pick_fb ? {drive_in.fb_val, drive_in.process_value_low, drive_in.process_value_high} :
		pick_freq ? {drive_in.pulse_out_motor_freq, 16'h0, drive_in.freq_high} :
		pick_amps ? {drive_in.amps, 16'h0, drive_in.inverter_rated_amps} :
		pick_pow ? {drive_in.power, 16'h0, drive_in.power_nom} :
		{drive_in.temp_c, TEMP_LOW_C, TEMP_HIGH_C};
	wire [15:0] span = (scl.high > scl.low) ? 16'(scl.high - scl.low) : 16'h0;
	wire [15:0] off_raw = (scl.value > scl.low) ? 16'(scl.value - scl.low) : 16'h0;
	wire [15:0] off = (off_raw > span) ? span : off_raw;
	wire [29:0] inc = off * pmax_r;
	wire [42:0] thr = span * HALF_HZ;
	wire [43:0] sum = {1'b0, acc_r} + {14'h0, inc};
	wire [43:0] diff = sum - {1'b0, thr};
	wire wrap = is_pulse && (span != 16'h0) && (sum >= {1'b0, thr});
	wire stat_ok = ((sel_r != SEL_RST) && (sel_r <= SEL_STAT_LAST)) ||
		((sel_r >= SEL_STAT2_FIRST) && (sel_r <= SEL_STAT2_LAST));
	wire level = (sel_r == SEL_CTRL_BIT) ? ctrl_word_in[CTRL_BIT_POS] :
		is_pulse ? (dout_r ^ wrap) :
		stat_ok ? status_cond_in[sel_r] : 1'b0;

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			acc_r <= 43'h0;
			dout_r <= 1'b0;
		end else begin
			acc_r <= !is_pulse ? 43'h0 : wrap ? diff[42:0] : sum[42:0];
			dout_r <= level;
		end
	end

	// Precise stop sequencing
	wire cnt_mode = (mode_r != MODE_RAMP) && (mode_r != MODE_SPD);
	wire comp_mode = mode_r >= MODE_SPD;
	wire rst_mode = (mode_r == MODE_CNT_RST) || (mode_r == MODE_SPD_CNT_RST);
	wire start_rise = start_in & ~start_d_r;
	// Every rising edge counts; at 200 MHz a 67.6 kHz input is far below the limit
	wire cp_edge = count_pulse_in & ~cpin_d_r;
	wire hit = cnt_mode && (cnt_r >= target_r);
	wire ms_tick = ms_cnt_r == 32'(MS_CYCLES - 1);
	wire dly_done = dly_acc_r >= {1'b0, dly_goal_r};
	wire [15:0] fmax = drive_in.freq_high;
	wire [15:0] short = (speed_in < fmax) ? 16'(fmax - speed_in) : 16'h0;
	wire [22:0] goal_nxt = 23'(short * delay_r);
	wire run_nxt = (state_nxt == POPS_RUN) || (state_nxt == POPS_DELAY);

	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			POPS_IDLE: begin
				if (start_rise) begin
					state_nxt = POPS_RUN;
				end
			end
			POPS_RUN: begin
				if (hit) begin
					state_nxt = POPS_RAMP;
				end else if (!start_in) begin
					state_nxt = comp_mode ? POPS_DELAY : POPS_RAMP;
				end
			end
			POPS_DELAY: begin
				if (hit || dly_done) begin
					state_nxt = POPS_RAMP;
				end
			end
			POPS_RAMP: begin
				if (speed_in == 16'h0) begin
					state_nxt = POPS_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			state_r <= POPS_IDLE;
			run_r <= 1'b0;
			stop_r <= 1'b0;
			start_d_r <= 1'b0;
			cpin_d_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			run_r <= run_nxt;
			// Internal stop stands until the next start edge
			stop_r <= (state_r != POPS_IDLE && hit) | (stop_r & ~start_rise);
			start_d_r <= start_in;
			cpin_d_r <= count_pulse_in;
		end
	end

	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			cnt_r <= 20'h0;
			ramp_cnt_r <= 20'h0;
		end else if (state_r == POPS_IDLE) begin
			if (start_rise) begin
				cnt_r <= rst_mode ? 20'h0 : ramp_cnt_r;
				ramp_cnt_r <= 20'h0;
			end
		end else if (state_r == POPS_RAMP) begin
			if (state_nxt == POPS_IDLE && rst_mode) begin
				ramp_cnt_r <= 20'h0;
			end else if (cp_edge && ramp_cnt_r != 20'hfffff) begin
				ramp_cnt_r <= 20'(ramp_cnt_r + 20'h1);
			end
		end else if (cp_edge && cnt_r != 20'hfffff) begin
			cnt_r <= 20'(cnt_r + 20'h1);
		end
	end

	// Delay grows linearly from zero at top speed to the full setting at standstill
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			ms_cnt_r <= 32'h0;
			dly_acc_r <= 24'h0;
			dly_goal_r <= 23'h0;
		end else if (state_r != POPS_DELAY) begin
			ms_cnt_r <= 32'h0;
			dly_acc_r <= 24'h0;
			dly_goal_r <= goal_nxt;
		end else begin
			ms_cnt_r <= ms_tick ? 32'h0 : 32'(ms_cnt_r + 32'h1);
			dly_acc_r <= ms_tick ? 24'(dly_acc_r + {8'h0, fmax}) : dly_acc_r;
		end
	end

	assign wb_ack_out = ack_r;
	assign wb_dat_out = rdat_r;
	assign dout_out = dout_r;
	assign run_out = run_r;
	assign stop_out = stop_r;

	default clocking cb @(posedge clock_in);
	endclocking
	default disable iff (srst_in);

	a_bus_ack_once: assert property (ack_r |=> !ack_r)
		else $error("ack held longer than one cycle");
	a_bus_ack_next: assert property (wb_cyc_in && wb_stb_in && !ack_r |=> ack_r)
		else $error("request not answered in one cycle");
	a_pulse_max_range: assert property (pmax_r >= PMAX_MIN_HZ && pmax_r <= PMAX_MAX_HZ)
		else $error("full-scale rate out of range");
	a_target_range: assert property (target_r <= TARGET_MAX)
		else $error("count target out of range");
	a_delay_range: assert property (delay_r <= DELAY_MAX_MS)
		else $error("delay setting out of range");
	a_ctrl_bit_follow: assert property (sel_r == SEL_CTRL_BIT && $stable(sel_r) |->
		dout_r == $past(ctrl_word_in[CTRL_BIT_POS]))
		else $error("output does not follow control bit");
	a_status_follow: assert property (stat_ok && $stable(sel_r) |->
		dout_r == $past(status_cond_in[sel_r]))
		else $error("output does not follow status");
	a_zero_span_quiet: assert property (is_pulse && span == 16'h0 && $stable(sel_r) |=>
		$stable(dout_r))
		else $error("pulses with empty range");
	a_start_edge_run: assert property (state_r == POPS_IDLE && start_rise |=>
		state_r == POPS_RUN && run_out)
		else $error("start edge did not start counting");
	a_count_stop: assert property (state_r == POPS_RUN && hit |=>
		state_r == POPS_RAMP && !run_out && stop_out)
		else $error("target reached without internal stop");
	a_plain_stop: assert property (state_r == POPS_RUN && !hit && !start_in && !comp_mode |=>
		!run_out)
		else $error("uncompensated stop was delayed");
	a_reset_clears: assert property (state_r == POPS_RAMP && speed_in == 16'h0 && rst_mode |=>
		state_r == POPS_IDLE && ramp_cnt_r == 20'h0)
		else $error("ramp count kept in reset mode");

	c_pulse_toggle: cover property (is_pulse && wrap ##1 !wrap);
	c_count_stop: cover property (state_r == POPS_RUN && hit);
	c_comp_delay: cover property (state_r == POPS_DELAY ##1 state_r == POPS_RAMP);
	c_write_ack: cover property (wr ##1 !ack_r);
endmodule : pops_top
`default_nettype wire
